// ===== design/ssl_engine.sv
// Line request engine with APB registers, buffer and interrupt
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module ssl_engine import ssl_pkg::*; #(
  parameter int unsigned RX_IDLE_CYCLES = RX_IDLE_CYC,
  parameter int unsigned DS_WAIT_CYCLES = DS_WAIT_CYC,
  parameter int unsigned SPACE_CYCLES = SPACE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Line side
  input wire ssl_line_in_type line_in,
  output ssl_line_out_type line_out,
  // Interrupt
  output logic irq
);
  ssl_state_type state_r, state_nxt;
  logic [7:0] code_r, code_nxt, asc_r, asc_nxt, cmp_r, cmp_nxt, res_r, res_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [7:0] ptr_r, ptr_nxt, bufidx_r, bufidx_nxt;
  logic exc_r, exc_nxt, par_r, par_nxt, open_r, open_nxt;
  logic closed_r, closed_nxt, mchk_r, mchk_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt, sp_r, sp_nxt;
  ssl_line_out_type tx_r, tx_nxt;
  logic [1:0] int_st_r, int_st_nxt, int_mask_r, int_mask_nxt, evt;
  logic rd_pend_r, rd_pend_nxt, rd_buf_r, rd_buf_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic apb_acc, buf_sel, busy, buf_go, reg_wr, req_wr, spacing;
  logic line_busy, busy_any, halt_open, halt_read, is_turn, is_disc, rx_ok;
  logic [7:0] fault;
  logic m_en, m_we;
  logic [7:0] m_addr, m_wd, m_q;

  // ==========================================================
  // APB decode
  assign apb_acc = psel && penable;
  assign buf_sel = paddr == OFF_BUF;
  assign busy = state_r != ST_IDLE;
  assign pready = pwrite ? !(buf_sel && busy) : rd_pend_r;
  assign pslverr = pready && !ssl_addr_ok(paddr);
  assign reg_wr = apb_acc && pwrite && pready && ssl_addr_ok(paddr);
  assign req_wr = reg_wr && paddr == OFF_REQ;
  assign buf_go = apb_acc && buf_sel && !busy && (pwrite || !rd_pend_r);
  assign prdata = rd_buf_r ? {24'h000000, m_q} : prdata_r;
  assign rd_pend_nxt = apb_acc && !pwrite && !rd_pend_r && !(buf_sel && busy);
  assign rd_buf_nxt = rd_pend_nxt && buf_sel;
  assign irq = |(int_st_r & int_mask_r);
  assign line_out = tx_r;

  always_comb begin
    prdata_nxt = 32'h00000000;
    case (paddr)
      OFF_REQ: prdata_nxt[7:0] = code_r;
      OFF_STAT: begin
        prdata_nxt[7:0] = cmp_r;
        prdata_nxt[STAT_ASC_LSB +: 8] = asc_r;
        prdata_nxt[STAT_BUSY_BIT] = busy;
        prdata_nxt[STAT_OPEN_BIT] = open_r;
        prdata_nxt[STAT_MCHK_BIT] = mchk_r;
      end
      OFF_COUNT: prdata_nxt[15:0] = cnt_r;
      OFF_BUFIDX: prdata_nxt[7:0] = bufidx_r;
      OFF_INT_ST: prdata_nxt[1:0] = int_st_r;
      OFF_INT_MASK: prdata_nxt[1:0] = int_mask_r;
      default: prdata_nxt = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Line condition decode
  assign halt_open = req_wr && pwdata[7:0] == REQ_HALT_OPEN;
  assign halt_read = req_wr && pwdata[7:0] == REQ_HALT_READ;
  assign is_turn = line_in.rx_data == CHR_TURN;
  assign is_disc = line_in.rx_data == CHR_DISC;
  assign rx_ok = ssl_parity_ok(line_in.rx_data);
  assign spacing = sp_r == TMR_W'(SPACE_CYCLES);
  assign line_busy = state_r inside {ST_READ, ST_FLUSH, ST_WFETCH, ST_WSEND};
  assign busy_any = line_busy || state_r == ST_OPEN;

  always_comb begin
    fault = ASC_NONE;
    if (line_in.mcheck || mchk_r) begin
      fault = ASC_MCHK;
    end else if (line_busy && !line_in.dsr) begin
      fault = ASC_DSF;
    end else if (line_busy && spacing) begin
      fault = ASC_SPACE;
    end else if (line_busy && line_in.rx_valid && is_disc) begin
      fault = ASC_DISC;
    end
  end

  // ==========================================================
  // Request engine
  always_comb begin
    state_nxt = state_r;
    code_nxt = code_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    asc_nxt = asc_r;
    cmp_nxt = cmp_r;
    res_nxt = res_r;
    exc_nxt = exc_r;
    par_nxt = par_r;
    open_nxt = open_r;
    closed_nxt = closed_r;
    mchk_nxt = mchk_r || line_in.mcheck;
    tmr_nxt = (tmr_r != '0) ? tmr_r - TMR_W'(1) : tmr_r;
    sp_nxt = !line_in.line_space ? '0 : (spacing ? sp_r : sp_r + TMR_W'(1));
    tx_nxt = tx_r;
    evt = 2'h0;
    m_en = buf_go;
    m_we = buf_go && pwrite;
    m_addr = bufidx_r;
    m_wd = pwdata[7:0];
    bufidx_nxt = buf_go ? bufidx_r + 8'h01 : bufidx_r;
    if (reg_wr && paddr == OFF_BUFIDX) begin
      bufidx_nxt = pwdata[7:0];
    end
    if (reg_wr && paddr == OFF_COUNT && !busy) begin
      cnt_nxt = pwdata[15:0];
    end
    case (state_r)
      ST_IDLE: begin
        if (req_wr) begin
          code_nxt = pwdata[7:0];
          asc_nxt = ASC_NONE;
          cmp_nxt = 8'h00;
          res_nxt = ASC_NONE;
          exc_nxt = 1'b0;
          par_nxt = 1'b0;
          ptr_nxt = 8'h00;
          state_nxt = ST_CODE;
          if (mchk_r && !(pwdata[7:0] == REQ_OPEN && closed_r)) begin
            res_nxt = ASC_MCHK;
          end
          if (pwdata[7:0] == REQ_CLOSE) begin
            tx_nxt.dtr = 1'b0;
            open_nxt = 1'b0;
            closed_nxt = 1'b1;
          end else if (res_nxt == ASC_NONE) begin
            case (pwdata[7:0])
              REQ_OPEN: begin
                mchk_nxt = line_in.mcheck;
                closed_nxt = 1'b0;
                tx_nxt.dtr = 1'b1;
                tmr_nxt = TMR_W'(DS_WAIT_CYCLES);
                state_nxt = ST_OPEN;
              end
              REQ_READ: begin
                if (!open_r) begin
                  res_nxt = ASC_DSF;
                end else begin
                  tmr_nxt = TMR_W'(RX_IDLE_CYCLES);
                  state_nxt = ST_READ;
                end
              end
              REQ_WBLK, REQ_WMUL, REQ_WLAST: begin
                if (!open_r) begin
                  res_nxt = ASC_DSF;
                end else if (cnt_r != 16'h0000) begin
                  state_nxt = ST_WFETCH;
                end
              end
              REQ_WRAP_DS, REQ_SENSE, REQ_PREWRAP, REQ_WRAP_AD: begin
                exc_nxt = 1'b0;
              end
              default: exc_nxt = 1'b1;
            endcase
          end
        end
      end
      ST_OPEN: begin
        if (line_in.dsr) begin
          open_nxt = 1'b1;
          state_nxt = ST_CODE;
        end else if (halt_open) begin
          exc_nxt = 1'b1;
          tx_nxt.dtr = 1'b0;
          state_nxt = ST_CODE;
        end else if (tmr_r == '0) begin
          res_nxt = ASC_DSF;
          tx_nxt.dtr = 1'b0;
          state_nxt = ST_CODE;
        end
      end
      ST_READ: begin
        if (halt_read) begin
          exc_nxt = 1'b1;
          state_nxt = ST_CODE;
        end else if (line_in.rx_valid) begin
          tmr_nxt = TMR_W'(RX_IDLE_CYCLES);
          if (is_turn) begin
            res_nxt = par_r ? ASC_PARITY : ASC_NONE;
            state_nxt = ST_CODE;
          end else if (cnt_r == 16'h0000) begin
            state_nxt = ST_FLUSH;
          end else begin
            m_en = 1'b1;
            m_we = 1'b1;
            m_addr = ptr_r;
            m_wd = rx_ok ? line_in.rx_data : CHR_HYPHEN;
            par_nxt = par_r || !rx_ok;
            ptr_nxt = ptr_r + 8'h01;
            cnt_nxt = cnt_r - 16'h0001;
          end
        end else if (tmr_r == '0) begin
          res_nxt = ASC_TIMEOUT;
          state_nxt = ST_CODE;
        end
      end
      ST_FLUSH: begin
        if (halt_read) begin
          exc_nxt = 1'b1;
          state_nxt = ST_CODE;
        end else if (line_in.rx_valid) begin
          tmr_nxt = TMR_W'(RX_IDLE_CYCLES);
          if (is_turn) begin
            res_nxt = ASC_OVF;
            state_nxt = ST_CODE;
          end
        end else if (tmr_r == '0) begin
          res_nxt = ASC_TIMEOUT;
          state_nxt = ST_CODE;
        end
      end
      ST_WFETCH: begin
        m_en = 1'b1;
        m_we = 1'b0;
        m_addr = ptr_r;
        state_nxt = ST_WSEND;
      end
      ST_WSEND: begin
        if (!tx_r.tx_valid) begin
          tx_nxt.tx_data = m_q;
          tx_nxt.tx_valid = 1'b1;
        end else if (line_in.tx_ready) begin
          tx_nxt.tx_valid = 1'b0;
          ptr_nxt = ptr_r + 8'h01;
          cnt_nxt = cnt_r - 16'h0001;
          state_nxt = (cnt_r == 16'h0001) ? ST_CODE : ST_WFETCH;
        end
      end
      ST_CODE: begin
        asc_nxt = res_r;
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        cmp_nxt = 8'h00;
        cmp_nxt[CMP_DONE_BIT] = 1'b1;
        cmp_nxt[CMP_ERR_BIT] = asc_r != ASC_NONE;
        cmp_nxt[CMP_EXC_BIT] = exc_r;
        evt = {asc_r != ASC_NONE, 1'b1};
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (busy_any && fault != ASC_NONE) begin
      res_nxt = fault;
      state_nxt = ST_CODE;
      tx_nxt.tx_valid = 1'b0;
    end
    int_st_nxt = int_st_r & ~((reg_wr && paddr == OFF_INT_ST) ? pwdata[1:0] : 2'h0);
    int_st_nxt = int_st_nxt | evt;
    int_mask_nxt = (reg_wr && paddr == OFF_INT_MASK) ? pwdata[1:0] : int_mask_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      code_r <= 8'h00;
      cnt_r <= RST_COUNT;
      ptr_r <= 8'h00;
      asc_r <= 8'h00;
      cmp_r <= 8'h00;
      res_r <= 8'h00;
      exc_r <= 1'b0;
      par_r <= 1'b0;
      open_r <= 1'b0;
      closed_r <= 1'b0;
      mchk_r <= 1'b0;
      tmr_r <= '0;
      sp_r <= '0;
      tx_r <= '0;
      bufidx_r <= 8'h00;
      int_st_r <= 2'h0;
      int_mask_r <= RST_INT_MASK;
      rd_pend_r <= 1'b0;
      rd_buf_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (ce) begin
      state_r <= state_nxt;
      code_r <= code_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      asc_r <= asc_nxt;
      cmp_r <= cmp_nxt;
      res_r <= res_nxt;
      exc_r <= exc_nxt;
      par_r <= par_nxt;
      open_r <= open_nxt;
      closed_r <= closed_nxt;
      mchk_r <= mchk_nxt;
      tmr_r <= tmr_nxt;
      sp_r <= sp_nxt;
      tx_r <= tx_nxt;
      bufidx_r <= bufidx_nxt;
      int_st_r <= int_st_nxt;
      int_mask_r <= int_mask_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_buf_r <= rd_buf_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  ssl_buf_ram u_buf (
    .pclk(pclk),
    .ce(ce),
    .en(m_en),
    .we(m_we),
    .addr(m_addr),
    .wdata(m_wd),
    .rdata(m_q)
  );

  // ==========================================================
  // Checks
  sequence s_report(logic [7:0] c);
    state_r == ST_CODE && res_r == c;
  endsequence
  property p_code_first;
    @(posedge pclk) disable iff (!presetn)
      $rose(cmp_r[CMP_ERR_BIT]) |-> asc_r != ASC_NONE && $stable(asc_r);
  endproperty
  a_code_first: assert property (p_code_first) else $error("code after error bit");
  property p_cmp_layout;
    @(posedge pclk) disable iff (!presetn) cmp_r[3:0] == 4'h0 && !cmp_r[7];
  endproperty
  a_cmp_layout: assert property (p_cmp_layout) else $error("bad completion bits");
  property p_err_iff_code;
    @(posedge pclk) disable iff (!presetn)
      cmp_r[CMP_DONE_BIT] |-> cmp_r[CMP_ERR_BIT] == (asc_r != ASC_NONE);
  endproperty
  a_err_iff_code: assert property (p_err_iff_code) else $error("error bit mismatch");
  property p_hyphen;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_READ && line_in.rx_valid && !halt_read && cnt_r != 16'h0000 &&
      !is_turn && !rx_ok |-> m_we && m_wd == CHR_HYPHEN;
  endproperty
  a_hyphen: assert property (p_hyphen) else $error("bad byte not hyphen");
  property p_flush;
    @(posedge pclk) disable iff (!presetn)
      state_r == ST_FLUSH |-> !m_we;
  endproperty
  a_flush: assert property (p_flush) else $error("store while flushing");
  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == ST_FLUSH && line_in.rx_valid && is_turn && !halt_read &&
      fault == ASC_NONE |=> s_report(ASC_OVF);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not reported");
  property p_disc;
    @(posedge pclk) disable iff (!presetn)
      ce && fault == ASC_DISC |=> s_report(ASC_DISC);
  endproperty
  a_disc: assert property (p_disc) else $error("disconnect not reported");
  property p_mchk;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == ST_IDLE && req_wr && mchk_r && pwdata[7:0] != REQ_OPEN
      |=> s_report(ASC_MCHK);
  endproperty
  a_mchk: assert property (p_mchk) else $error("machine check not reported");
  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      ce && state_r == ST_READ && tmr_r == '0 && !line_in.rx_valid && !halt_read &&
      fault == ASC_NONE |=> s_report(ASC_TIMEOUT);
  endproperty
  a_timeout: assert property (p_timeout) else $error("idle timeout missed");
endmodule : ssl_engine

// ===== design/ssl_pkg.sv
// Shared constants, types and helpers of the line request engine
package ssl_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned RX_IDLE_SEC = 25;
  localparam int unsigned RX_IDLE_CYC = RX_IDLE_SEC * CLK_HZ;
  localparam int unsigned DS_WAIT_MS = 100;
  localparam int unsigned DS_WAIT_CYC = DS_WAIT_MS * (CLK_HZ / 1000);
  localparam int unsigned SPACE_MS = 500;
  localparam int unsigned SPACE_CYC = SPACE_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W = 30;

  // ==========================================================
  // Request codes
  localparam logic [7:0] REQ_WRAP_DS = 8'h00;
  localparam logic [7:0] REQ_SENSE = 8'h01;
  localparam logic [7:0] REQ_PREWRAP = 8'h05;
  localparam logic [7:0] REQ_WRAP_AD = 8'h09;
  localparam logic [7:0] REQ_CLOSE = 8'h30;
  localparam logic [7:0] REQ_OPEN = 8'h40;
  localparam logic [7:0] REQ_WBLK = 8'h42;
  localparam logic [7:0] REQ_READ = 8'h43;
  localparam logic [7:0] REQ_WMUL = 8'h46;
  localparam logic [7:0] REQ_WLAST = 8'h4a;
  localparam logic [7:0] REQ_HALT_OPEN = 8'hc0;
  localparam logic [7:0] REQ_HALT_READ = 8'hc3;

  // ==========================================================
  // Completion byte bits and adapter status codes
  localparam int unsigned CMP_DONE_BIT = 4;
  localparam int unsigned CMP_ERR_BIT = 5;
  localparam int unsigned CMP_EXC_BIT = 6;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_PARITY = 8'h80;
  localparam logic [7:0] ASC_DSF = 8'h40;
  localparam logic [7:0] ASC_SPACE = 8'h20;
  localparam logic [7:0] ASC_OVF = 8'h10;
  localparam logic [7:0] ASC_DISC = 8'h08;
  localparam logic [7:0] ASC_MCHK = 8'h04;
  localparam logic [7:0] ASC_TIMEOUT = 8'h02;

  // ==========================================================
  // Characters
  localparam logic [7:0] CHR_HYPHEN = 8'h2d;
  localparam logic [7:0] CHR_DISC = 8'h04;
  localparam logic [7:0] CHR_TURN = 8'h0d;

  // ==========================================================
  // Register map and reset values
  localparam logic [7:0] OFF_REQ = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_BUF = 8'h0c;
  localparam logic [7:0] OFF_BUFIDX = 8'h10;
  localparam logic [7:0] OFF_INT_ST = 8'h14;
  localparam logic [7:0] OFF_INT_MASK = 8'h18;
  localparam int unsigned STAT_ASC_LSB = 8;
  localparam int unsigned STAT_BUSY_BIT = 16;
  localparam int unsigned STAT_OPEN_BIT = 17;
  localparam int unsigned STAT_MCHK_BIT = 18;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0] RST_INT_MASK = 2'h0;
  localparam int unsigned BUF_AW = 8;

  // ==========================================================
  // Types
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_OPEN = 8'h02, ST_READ = 8'h04, ST_FLUSH = 8'h08,
    ST_WFETCH = 8'h10, ST_WSEND = 8'h20, ST_CODE = 8'h40, ST_DONE = 8'h80
  } ssl_state_type;

  typedef struct packed {
    logic rx_valid;
    logic [7:0] rx_data;
    logic line_space;
    logic dsr;
    logic mcheck;
    logic tx_ready;
  } ssl_line_in_type;

  typedef struct packed {
    logic tx_valid;
    logic [7:0] tx_data;
    logic dtr;
  } ssl_line_out_type;

  // ==========================================================
  // Helpers
  function automatic logic ssl_parity_ok(input logic [7:0] b);
    return ~^b;
  endfunction : ssl_parity_ok

  function automatic logic ssl_addr_ok(input logic [7:0] a);
    return a == OFF_REQ || a == OFF_STAT || a == OFF_COUNT || a == OFF_BUF ||
      a == OFF_BUFIDX || a == OFF_INT_ST || a == OFF_INT_MASK;
  endfunction : ssl_addr_ok

endpackage : ssl_pkg

// ===== design/ssl_buf_ram.sv
// Byte buffer for received and transmitted characters
`timescale 1ns/100ps
module ssl_buf_ram import ssl_pkg::*; (
  // Clock
  input wire logic pclk,
  input wire logic ce,
  // Port
  input wire logic en,
  input wire logic we,
  input wire logic [BUF_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<BUF_AW)-1];

  // ==========================================================
  // Storage with registered read
  always_ff @(posedge pclk) begin
    if (ce && en) begin
      if (we) begin
        mem[addr] <= wdata;
      end else begin
        rdata <= mem[addr];
      end
    end
  end
endmodule : ssl_buf_ram

// ===== dv/ssl_term_model.sv
// Terminal and data set model facing the line side
`timescale 1ns/100ps
module ssl_term_model import ssl_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line
  input wire ssl_line_out_type line_out,
  output ssl_line_in_type line_in
);
  logic dsr_ok = 1'b1;
  logic space_on = 1'b0;
  logic mck = 1'b0;
  logic rv = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic tr;
  logic dsr_r;
  int wait_n;
  logic [7:0] txq[$];

  // ==========================================================
  // Data set follows terminal ready, consumer stalls 4 cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_r <= 1'b0;
      tr <= 1'b0;
      wait_n <= 0;
    end else begin
      dsr_r <= line_out.dtr & dsr_ok;
      if (tr && line_out.tx_valid) begin
        txq.push_back(line_out.tx_data);
        tr <= 1'b0;
        wait_n <= 0;
      end else if (line_out.tx_valid && wait_n == 3) begin
        tr <= 1'b1;
      end else if (line_out.tx_valid) begin
        wait_n <= wait_n + 1;
      end
    end
  end
  assign line_in = {rv, rx_byte, space_on, dsr_r, mck, tr};

  // ==========================================================
  // One received character, data inverted after the strobe
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rv <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rv <= 1'b0;
    rx_byte <= ~b;
    repeat (4) @(posedge pclk);
  endtask : send
endmodule : ssl_term_model

// ===== dv/tb_top.sv
// Self-checking bench for the line request engine
`timescale 1ns/100ps
module tb_top import ssl_pkg::*; ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  ssl_line_in_type line_in;
  ssl_line_out_type line_out;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [31:0] rdat;
  logic rerr;
  int i;
  logic [7:0] codes [7] = '{REQ_WRAP_DS, REQ_SENSE, REQ_PREWRAP, REQ_WRAP_AD,
    REQ_HALT_OPEN, REQ_HALT_READ, 8'h77};
  logic [7:0] wcodes [3] = '{REQ_WBLK, REQ_WMUL, REQ_WLAST};

  ssl_engine #(.RX_IDLE_CYCLES(200), .DS_WAIT_CYCLES(50), .SPACE_CYCLES(30)) i_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
    .irq(irq));
  ssl_term_model i_term (.pclk(pclk), .presetn(presetn), .line_out(line_out),
    .line_in(line_in));

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================
  // Verdict, compare and bus tasks
  task automatic tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      error_cnt++;
      tally_and_finish;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic chk_irq(input logic exp);
    @(negedge pclk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  task automatic req(input logic [7:0] code);
    wr(OFF_INT_ST, 32'h3);
    wr(OFF_REQ, {24'h0, code});
  endtask : req

  // Wait for completion, then check completion nibble and status code
  task automatic fin(input logic [3:0] nib, input logic [7:0] asc);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_INT_ST, 32'h0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      error_cnt++;
      tally_and_finish;
    end
    apb(1'b0, OFF_STAT, 32'h0);
    chk({20'h0, rdat[15:4]}, {20'h0, asc, nib});
  endtask : fin

  task automatic run(input logic [7:0] code, input logic [3:0] nib, input logic [7:0] asc);
    req(code);
    fin(nib, asc);
  endtask : run

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_INT_MASK, 32'h0);
    rd(OFF_COUNT, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk({rdat[31:1], rerr}, 32'h1);
    for (i = 0; i < 7; i++) begin
      run(codes[i], (i < 4) ? 4'h1 : 4'h5, ASC_NONE);
    end
    wr(OFF_INT_MASK, 32'h2);
    ce <= 1'b0;
    wr(OFF_INT_MASK, 32'h0);
    ce <= 1'b1;
    rd(OFF_INT_MASK, 32'h2);
    run(REQ_READ, 4'h3, ASC_DSF);
    chk_irq(1'b1);
    wr(OFF_INT_ST, 32'h3);
    chk_irq(1'b0);
    run(REQ_SENSE, 4'h1, ASC_NONE);
    chk_irq(1'b0);
    i_term.dsr_ok <= 1'b0;
    run(REQ_OPEN, 4'h3, ASC_DSF);
    i_term.dsr_ok <= 1'b1;
    run(REQ_OPEN, 4'h1, ASC_NONE);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rdat[STAT_OPEN_BIT]}, 32'h1);
    wr(OFF_COUNT, 32'h3);
    req(REQ_READ);
    i_term.send(8'h41);
    i_term.send(8'h43);
    i_term.send(CHR_TURN);
    fin(4'h3, ASC_PARITY);
    wr(OFF_BUFIDX, 32'h0);
    rd(OFF_BUF, 32'h41);
    rd(OFF_BUF, {24'h0, CHR_HYPHEN});
    wr(OFF_COUNT, 32'h1);
    req(REQ_READ);
    i_term.send(8'h41);
    i_term.send(8'h42);
    i_term.send(CHR_TURN);
    fin(4'h3, ASC_OVF);
    wr(OFF_BUFIDX, 32'h1);
    rd(OFF_BUF, {24'h0, CHR_HYPHEN});
    wr(OFF_COUNT, 32'h1);
    req(REQ_READ);
    i_term.send(8'h41);
    i_term.send(8'h42);
    fin(4'h3, ASC_TIMEOUT);
    run(REQ_READ, 4'h3, ASC_TIMEOUT);
    wr(OFF_COUNT, 32'h4);
    req(REQ_READ);
    i_term.send(CHR_DISC);
    fin(4'h3, ASC_DISC);
    req(REQ_READ);
    i_term.space_on <= 1'b1;
    fin(4'h3, ASC_SPACE);
    i_term.space_on <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(OFF_BUFIDX, 32'h0);
      wr(OFF_BUF, 32'h55);
      wr(OFF_BUF, 32'h66);
      wr(OFF_COUNT, 32'h2);
      run(wcodes[i], 4'h1, ASC_NONE);
      chk({24'h0, i_term.txq[2 * i]}, 32'h55);
      chk({24'h0, i_term.txq[2 * i + 1]}, 32'h66);
    end
    wr(OFF_COUNT, 32'h4);
    req(REQ_READ);
    wr(OFF_REQ, {24'h0, REQ_HALT_READ});
    fin(4'h5, ASC_NONE);
    req(REQ_READ);
    i_term.dsr_ok <= 1'b0;
    fin(4'h3, ASC_DSF);
    i_term.dsr_ok <= 1'b1;
    run(REQ_CLOSE, 4'h1, ASC_NONE);
    i_term.dsr_ok <= 1'b0;
    req(REQ_OPEN);
    wr(OFF_REQ, {24'h0, REQ_HALT_OPEN});
    fin(4'h5, ASC_NONE);
    i_term.dsr_ok <= 1'b1;
    run(REQ_OPEN, 4'h1, ASC_NONE);
    i_term.mck <= 1'b1;
    run(REQ_SENSE, 4'h3, ASC_MCHK);
    i_term.mck <= 1'b0;
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rdat[STAT_MCHK_BIT]}, 32'h1);
    run(REQ_CLOSE, 4'h3, ASC_MCHK);
    run(REQ_OPEN, 4'h1, ASC_NONE);
    apb(1'b0, OFF_STAT, 32'h0);
    chk({31'h0, rdat[STAT_MCHK_BIT]}, 32'h0);
    tally_and_finish;
  end
endmodule : tb_top
